//--- design/option_strap_pkg.sv
// Constants shared by the option strap decoder and the transmit keyer.
package option_strap_pkg;

  // System clock rate and the derived cycle counts.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned HANG_STEP_MS = 1;
  localparam int unsigned HANG_STEP_CYCLES = (CLK_HZ / MS_PER_S) * HANG_STEP_MS;

  // Remote link rates in baud, index 0 is the rate with every switch open.
  localparam int unsigned NUM_RATES = 9;
  localparam int unsigned BAUD_RATE_0 = 110;
  localparam int unsigned BAUD_RATE_1 = 300;
  localparam int unsigned BAUD_RATE_2 = 600;
  localparam int unsigned BAUD_RATE_3 = 1200;
  localparam int unsigned BAUD_RATE_4 = 2400;
  localparam int unsigned BAUD_RATE_5 = 4800;
  localparam int unsigned BAUD_RATE_6 = 9600;
  localparam int unsigned BAUD_RATE_7 = 19200;
  localparam int unsigned BAUD_RATE_8 = 38400;
  localparam int unsigned BAUD_DIV_W = 18;
  localparam int unsigned RATE_IDX_W = 4;

  // Unit address decoding.
  localparam int unsigned UNIT_W = 4;
  localparam int unsigned CHAN_W = 5;
  localparam logic [3:0] UNIT_ALL_OPEN = 4'h9;

  // Hang delay in milliseconds, four BCD digits.
  localparam int unsigned HANG_W = 14;
  localparam logic [13:0] HANG_MIN_MS = 14'h0001;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam int unsigned PRE_W = 16;

  // Jumper encodings: 0 is the factory setting.
  localparam logic FMT_RS232 = 1'b0;
  localparam logic FMT_MIL188 = 1'b1;
  localparam logic TONE_AUTO = 1'b0;
  localparam logic TONE_ALWAYS = 1'b1;

  // Register port.
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] DELAY_OFS = 4'h4;
  localparam logic [3:0] CTRL_OFS = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Field positions.
  localparam int unsigned ST_KEY_BIT = 0;
  localparam int unsigned ST_TONE_BIT = 1;
  localparam int unsigned ST_HANG_BIT = 2;
  localparam int unsigned ST_RATE_LSB = 4;
  localparam int unsigned ST_UNIT_LSB = 8;
  localparam int unsigned ST_CHLO_LSB = 16;
  localparam int unsigned ST_CHHI_LSB = 24;
  localparam int unsigned CTRL_KEY_BIT = 0;
  localparam int unsigned CTRL_TONE_BIT = 1;

endpackage : option_strap_pkg

//--- design/pin_filter_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module pin_filter_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  // Stage one feeds only stage two; the filter compares stages two and three per bit.
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.filt[i] = st_q.s3[i];
      end
    end
  end

  // Reset loads the idle level so no false edge appears after release.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= {INIT, INIT, INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_out = st_q.filt;

endmodule : pin_filter_sync

//--- design/option_strap_automute_keyer.sv
// Option strap decoder with transmit keying timer for the FSK modem control board.
//
// Behaviour
// - Remote serial rate 110 to 38400 baud from baud switches, default 9600.
// - Several baud switches closed: the highest selected rate is used.
// - Several address switches closed: the lowest unit number is used.
// - Address sets unit 01 to 09 and modulator and demodulator channels.
// - Transmit data activity closes the keyline at once.
// - Data resting steady opens the keyline only after the hang delay.
// - Hang delay spans 1 ms to 9.999 s in 1 ms steps.
// - Hang delay read as four BCD digits from sixteen switch positions.
// - High bank seconds and hundreds, low bank tens and ones, weight 8 first.
// - Factory switch setting gives a 250 ms hang delay.
// - Data port jumper picks RS-232 or MIL-188 transmit data polarity.
// - Mid-bit clock edge at every received bit centre, polarity by jumper.
// - Remote port format jumper inverts remote lines only, default RS-232.
// - Keyline always follows activity and hang; tone jumper gates tones or leaves them on.
// - Direct key request enables tones and closes the keyline at once.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module option_strap_automute_keyer
  import option_strap_pkg::*;
#(
  parameter int unsigned MS_CYCLES = option_strap_pkg::HANG_STEP_CYCLES,
  parameter int unsigned CLOCK_HZ = option_strap_pkg::CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] remote_baud_select_switch,
  input wire logic [7:0] unit_address_switch,
  input wire logic [7:0] hang_delay_low_bank,
  input wire logic [7:0] hang_delay_high_bank,
  input wire logic tx_data_polarity_jumper,
  input wire logic rx_midbit_clock_polarity_jumper,
  input wire logic remote_port_format_jumper,
  input wire logic tone_gating_jumper,
  input wire logic tx_data_pin,
  input wire logic direct_key_request,
  input wire logic rx_bit_edge,
  input wire logic rx_bit_centre,
  input wire logic remote_tx_serial,
  input wire logic remote_rx_line,
  input wire logic [option_strap_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [option_strap_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [option_strap_pkg::DATA_W-1:0] reg_rdata,
  output logic keyline_closed,
  output logic tone_enable,
  output logic mod_data,
  output logic rx_midbit_clock,
  output logic baud_tick,
  output logic [option_strap_pkg::RATE_IDX_W-1:0] baud_rate_index,
  output logic [option_strap_pkg::UNIT_W-1:0] unit_number,
  output logic [option_strap_pkg::CHAN_W-1:0] demod_channel,
  output logic [option_strap_pkg::CHAN_W-1:0] mod_channel,
  output logic remote_tx_line,
  output logic remote_rx_serial
);
  import option_strap_pkg::*;

  localparam int unsigned SYNC_W = 38;

  typedef struct packed {
    logic [BAUD_DIV_W-1:0] baud_cnt;
    logic baud_tick;
    logic [RATE_IDX_W-1:0] rate_idx;
    logic [UNIT_W-1:0] unit;
    logic [CHAN_W-1:0] ch_lo;
    logic [CHAN_W-1:0] ch_hi;
    logic [HANG_W-1:0] delay_ms;
    logic [HANG_W-1:0] hang_ms;
    logic [PRE_W-1:0] pre_cnt;
    logic primed;
    logic prev_tx;
    logic keyed;
    logic tone_en;
    logic mod_data;
    logic midclk;
    logic remote_tx;
    logic remote_rx;
    logic soft_key;
    logic soft_tone;
    logic [DATA_W-1:0] rdata;
  } keyer_s;

  keyer_s st_q;
  keyer_s st_d;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic [7:0] baud_sw;
  logic [7:0] addr_sw;
  logic [7:0] low_bank;
  logic [7:0] high_bank;
  logic tx_s;
  logic dkr_s;
  logic txpol_s;
  logic rxpol_s;
  logic fmt_s;
  logic tone_j_s;
  logic rxl_s;
  logic edge_seen;
  logic key_req;
  logic [HANG_W-1:0] next_hang;

  // Switch, jumper, data and key pins pass the filtered synchroniser; remote_tx_serial and the bit strobes do not.
  assign pins_raw = {remote_baud_select_switch, unit_address_switch, hang_delay_low_bank,
                     hang_delay_high_bank, tx_data_polarity_jumper,
                     rx_midbit_clock_polarity_jumper, remote_port_format_jumper,
                     tone_gating_jumper, tx_data_pin, direct_key_request};

  pin_filter_sync #(
    .WIDTH(SYNC_W),
    .INIT(38'h00_0000_0000)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(pins_raw),
    .pin_out(pins_s)
  );

  // The remote receive line idles high, so its synchroniser resets to one.
  pin_filter_sync #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_rx_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(remote_rx_line),
    .pin_out(rxl_s)
  );

  assign baud_sw = pins_s[37:30];
  assign addr_sw = pins_s[29:22];
  assign low_bank = pins_s[21:14];
  assign high_bank = pins_s[13:6];
  assign txpol_s = pins_s[5];
  assign rxpol_s = pins_s[4];
  assign fmt_s = pins_s[3];
  assign tone_j_s = pins_s[2];
  assign tx_s = pins_s[1];
  assign dkr_s = pins_s[0];

  // Cycles per bit for a rate index; clock rate is a parameter so it can be rescaled.
  function automatic logic [BAUD_DIV_W-1:0] baud_div(input logic [RATE_IDX_W-1:0] idx);
    int unsigned rate;
    rate = BAUD_RATE_0;
    case (idx)
      4'h1: rate = BAUD_RATE_1;
      4'h2: rate = BAUD_RATE_2;
      4'h3: rate = BAUD_RATE_3;
      4'h4: rate = BAUD_RATE_4;
      4'h5: rate = BAUD_RATE_5;
      4'h6: rate = BAUD_RATE_6;
      4'h7: rate = BAUD_RATE_7;
      4'h8: rate = BAUD_RATE_8;
      default: rate = BAUD_RATE_0;
    endcase
    return BAUD_DIV_W'(CLOCK_HZ / rate);
  endfunction : baud_div

  // Highest closed baud switch wins; switch k selects rate index k+1.
  function automatic logic [RATE_IDX_W-1:0] rate_pick(input logic [7:0] sw);
    logic [RATE_IDX_W-1:0] idx;
    idx = 4'h0;
    for (int k = 0; k < 8; k++) begin
      if (sw[k]) begin
        idx = RATE_IDX_W'(k + 1);
      end
    end
    return idx;
  endfunction : rate_pick

  // Lowest closed address switch wins; all open gives the last unit.
  function automatic logic [UNIT_W-1:0] unit_pick(input logic [7:0] sw);
    logic [UNIT_W-1:0] u;
    u = UNIT_ALL_OPEN;
    for (int k = 7; k >= 0; k--) begin
      if (sw[k]) begin
        u = UNIT_W'(k + 1);
      end
    end
    return u;
  endfunction : unit_pick

  // A BCD digit above nine is clamped so a miswired switch cannot exceed the range.
  function automatic logic [HANG_W-1:0] bcd_digit(input logic [3:0] d);
    return (d > BCD_MAX) ? HANG_W'(BCD_MAX) : HANG_W'(d);
  endfunction : bcd_digit

  // Seconds and hundreds sit in the high bank, tens and ones in the low bank, MSB first.
  function automatic logic [HANG_W-1:0] bcd_ms(input logic [7:0] hi, input logic [7:0] lo);
    logic [HANG_W-1:0] ms;
    ms = bcd_digit(hi[7:4]) * 14'd1000 + bcd_digit(hi[3:0]) * 14'd100 +
         bcd_digit(lo[7:4]) * 14'd10 + bcd_digit(lo[3:0]);
    if (ms < HANG_MIN_MS) begin
      ms = HANG_MIN_MS;
    end
    return ms;
  endfunction : bcd_ms

  // Transmit activity is any change of the filtered data level after the first sample.
  assign edge_seen = st_q.primed && (tx_s != st_q.prev_tx);
  assign key_req = dkr_s | st_q.soft_key;

  // Hang count reloads on each transition and counts down in whole milliseconds.
  always_comb begin
    next_hang = st_q.hang_ms;
    if (edge_seen) begin
      next_hang = st_q.delay_ms;
    end else if ((st_q.hang_ms != '0) && (st_q.pre_cnt == PRE_W'(MS_CYCLES - 1))) begin
      next_hang = st_q.hang_ms - 14'd1;
    end
  end

  always_comb begin
    st_d = st_q;

    // Strap decoding is refreshed every cycle from the filtered switches.
    st_d.rate_idx = rate_pick(baud_sw);
    st_d.unit = unit_pick(addr_sw);
    st_d.ch_lo = CHAN_W'({st_d.unit, 1'b0} - 5'd1);
    st_d.ch_hi = CHAN_W'({st_d.unit, 1'b0});
    st_d.delay_ms = bcd_ms(high_bank, low_bank);

    // Remote rate divider restarts at the top whenever the selected rate changes.
    st_d.baud_tick = 1'b0;
    if ((st_q.baud_cnt == '0) || (st_d.rate_idx != st_q.rate_idx)) begin
      st_d.baud_cnt = baud_div(st_d.rate_idx) - 18'd1;
      st_d.baud_tick = (st_q.baud_cnt == '0);
    end else begin
      st_d.baud_cnt = st_q.baud_cnt - 18'd1;
    end

    // The millisecond prescaler restarts on each transition, so the delay is never short.
    st_d.primed = 1'b1;
    st_d.prev_tx = tx_s;
    st_d.hang_ms = next_hang;
    if (edge_seen || (st_q.hang_ms == '0) || (st_q.pre_cnt == PRE_W'(MS_CYCLES - 1))) begin
      st_d.pre_cnt = '0;
    end else begin
      st_d.pre_cnt = st_q.pre_cnt + 16'd1;
    end

    // Keyline follows activity, the hang count and any direct request.
    st_d.keyed = edge_seen || (next_hang != '0) || key_req;
    if (tone_j_s == TONE_ALWAYS || st_q.soft_tone) begin
      st_d.tone_en = 1'b1;
    end else begin
      st_d.tone_en = st_d.keyed;
    end

    // Data port polarity: the MIL-188 setting inverts the sense of the data line.
    st_d.mod_data = (txpol_s == FMT_MIL188) ? ~tx_s : tx_s;

    // Mid-bit clock rests at its pre-centre level and swings at each bit centre.
    if (rx_bit_centre) begin
      st_d.midclk = (rxpol_s == FMT_MIL188);
    end else if (rx_bit_edge) begin
      st_d.midclk = (rxpol_s != FMT_MIL188);
    end

    // Remote port format touches only the remote lines.
    st_d.remote_tx = (fmt_s == FMT_MIL188) ? ~remote_tx_serial : remote_tx_serial;
    st_d.remote_rx = (fmt_s == FMT_MIL188) ? ~rxl_s : rxl_s;

    // Register writes; unmapped writes are ignored.
    if (reg_wr && (reg_addr == CTRL_OFS)) begin
      st_d.soft_key = reg_wdata[CTRL_KEY_BIT];
      st_d.soft_tone = reg_wdata[CTRL_TONE_BIT];
    end

    // Read data stands for the one cycle after the strobe and is zero otherwise.
    st_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        STATUS_OFS: begin
          st_d.rdata[ST_KEY_BIT] = st_q.keyed;
          st_d.rdata[ST_TONE_BIT] = st_q.tone_en;
          st_d.rdata[ST_HANG_BIT] = (st_q.hang_ms != '0);
          st_d.rdata[ST_RATE_LSB +: RATE_IDX_W] = st_q.rate_idx;
          st_d.rdata[ST_UNIT_LSB +: UNIT_W] = st_q.unit;
          st_d.rdata[ST_CHLO_LSB +: CHAN_W] = st_q.ch_lo;
          st_d.rdata[ST_CHHI_LSB +: CHAN_W] = st_q.ch_hi;
        end
        DELAY_OFS: begin
          st_d.rdata[HANG_W-1:0] = st_q.delay_ms;
          st_d.rdata[16 +: HANG_W] = st_q.hang_ms;
        end
        CTRL_OFS: begin
          st_d.rdata[CTRL_KEY_BIT] = st_q.soft_key;
          st_d.rdata[CTRL_TONE_BIT] = st_q.soft_tone;
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end
  end

  // All state registers together; reset takes only constants.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.rate_idx <= 4'h0;
      st_q.unit <= UNIT_ALL_OPEN;
      st_q.ch_lo <= CHAN_W'({UNIT_ALL_OPEN, 1'b0} - 5'd1); // Pair agrees with unit 9 at once.
      st_q.ch_hi <= CHAN_W'({UNIT_ALL_OPEN, 1'b0});
      st_q.delay_ms <= HANG_MIN_MS;
      st_q.soft_key <= CTRL_RESET[CTRL_KEY_BIT];
      st_q.soft_tone <= CTRL_RESET[CTRL_TONE_BIT];
      st_q.midclk <= 1'b1;
      st_q.remote_tx <= 1'b1;
      st_q.remote_rx <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign keyline_closed = st_q.keyed;
  assign tone_enable = st_q.tone_en;
  assign mod_data = st_q.mod_data;
  assign rx_midbit_clock = st_q.midclk;
  assign baud_tick = st_q.baud_tick;
  assign baud_rate_index = st_q.rate_idx;
  assign unit_number = st_q.unit;
  assign demod_channel = st_q.ch_lo;
  assign mod_channel = st_q.ch_hi;
  assign remote_tx_line = st_q.remote_tx;
  assign remote_rx_serial = st_q.remote_rx;

endmodule : option_strap_automute_keyer

//--- sim/option_strap_monitor.sv
// Checker for the strap decoder and keyline timer outputs.
`timescale 1ns/1ps
module option_strap_monitor #(
  parameter int unsigned MS_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] hang_delay_low_bank,
  input wire logic [7:0] hang_delay_high_bank,
  input wire logic tone_gating_jumper,
  input wire logic rx_midbit_clock_polarity_jumper,
  input wire logic tx_data_pin,
  input wire logic direct_key_request,
  input wire logic rx_bit_centre,
  input wire logic keyline_closed,
  input wire logic tone_enable,
  input wire logic rx_midbit_clock,
  input wire logic [3:0] baud_rate_index,
  input wire logic [3:0] unit_number,
  input wire logic [4:0] demod_channel,
  input wire logic [4:0] mod_channel
);
  int lim;
  int quiet_q;
  int dk_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Hang length in cycles; only legal BCD digits are expected on the banks.
  assign lim = (hang_delay_high_bank[7:4] * 1000 + hang_delay_high_bank[3:0] * 100
    + hang_delay_low_bank[7:4] * 10 + hang_delay_low_bank[3:0]) * MS_CYCLES;
  // Cycles since the data pin last moved and since the direct request was last high.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      quiet_q <= 0;
      dk_q <= 0;
    end else begin
      quiet_q <= $changed(tx_data_pin) ? 0 : (quiet_q < 32'h3fff_ffff ? quiet_q + 1 : quiet_q);
      dk_q <= direct_key_request ? 0 : (dk_q < 1000 ? dk_q + 1 : dk_q);
    end
  end
  // Jumpers are synchronised, so a setting counts once it has stood for a while.
  sequence s_rs232; !rx_midbit_clock_polarity_jumper [*8]; endsequence
  sequence s_mil; rx_midbit_clock_polarity_jumper [*8]; endsequence
  sequence s_held_key; direct_key_request [*8]; endsequence
  AST_CHAN_PAIR: assert property (mod_channel == {unit_number, 1'b0} &&
    demod_channel == {unit_number, 1'b0} - 5'h1) else $error("channel pair wrong");
  AST_UNIT_RANGE: assert property (unit_number != 4'h0 && unit_number <= 4'h9)
    else $error("unit out of range");
  AST_RATE_RANGE: assert property (baud_rate_index <= 4'h8)
    else $error("rate index out of range");
  AST_KEY_FAST: assert property ($changed(tx_data_pin) |-> ##[1:6] keyline_closed)
    else $error("keyline late on data activity");
  AST_HOLD_MIN: assert property ($fell(keyline_closed) && dk_q > 16 |-> quiet_q >= lim)
    else $error("keyline opened before hang delay");
  AST_OPEN_LATE: assert property (quiet_q == lim + 10 && dk_q > 16 |-> !keyline_closed)
    else $error("keyline still closed after hang delay");
  AST_DIRECT_KEY: assert property (s_held_key |-> keyline_closed && tone_enable)
    else $error("direct request did not key");
  AST_TONE_ON: assert property (tone_gating_jumper [*8] |-> tone_enable)
    else $error("tones not held on");
  AST_MID_232: assert property (s_rs232 ##0 rx_bit_centre |=> !rx_midbit_clock)
    else $error("mid-bit clock did not fall");
  AST_MID_188: assert property (s_mil ##0 rx_bit_centre |=> rx_midbit_clock)
    else $error("mid-bit clock did not rise");
endmodule : option_strap_monitor

//--- sim/tx_data_terminal.sv
// Transmit data terminal model that sends bursts on the modem data input.
`timescale 1ns/1ps
module tx_data_terminal #(
  parameter int unsigned BIT_CYCLES = 8
) (
  input wire logic sys_clk,
  output logic tx_line
);
  // The line rests between bursts so the keyer sees no activity.
  initial tx_line = 1'b0;
  // One toggle per bit; returns at the edge of the last change.
  task automatic burst(input int unsigned n);
    for (int unsigned i = 0; i < n; i++) begin
      repeat (BIT_CYCLES) @(posedge sys_clk);
      tx_line <= ~tx_line;
    end
  endtask : burst
endmodule : tx_data_terminal

//--- sim/tb_top.sv
// Self-checking bench for the strap decoder and keyline timer.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t: got %0h expected %0h", $time, a, b); end end
module tb_top;
  import option_strap_pkg::*;
  localparam int unsigned MS_CYCLES = 20;
  localparam int unsigned CLOCK_HZ = 2_000_000;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] baud_sw = 8'h20, unit_sw = 8'h01, dly_lo = 8'h50, dly_hi = 8'h02;
  logic pol_j = 1'b0, mid_j = 1'b0, fmt_j = 1'b0, tone_j = 1'b0, dkr = 1'b0;
  logic bit_edge = 1'b0, bit_ctr = 1'b0, rtx_ser = 1'b1, rrx_line = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, rdata, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tx_pin, key, tone, mod_data, mid_clk, tick;
  logic rtx_line, rrx_ser;
  logic [3:0] rate_idx, unit;
  logic [4:0] demod_ch, mod_ch;
  int num_errors = 0;
  int checks_done = 0;
  option_strap_automute_keyer #(.MS_CYCLES(MS_CYCLES), .CLOCK_HZ(CLOCK_HZ)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .remote_baud_select_switch(baud_sw),
    .unit_address_switch(unit_sw), .hang_delay_low_bank(dly_lo), .hang_delay_high_bank(dly_hi),
    .tx_data_polarity_jumper(pol_j), .rx_midbit_clock_polarity_jumper(mid_j),
    .remote_port_format_jumper(fmt_j), .tone_gating_jumper(tone_j), .tx_data_pin(tx_pin),
    .direct_key_request(dkr), .rx_bit_edge(bit_edge), .rx_bit_centre(bit_ctr),
    .remote_tx_serial(rtx_ser), .remote_rx_line(rrx_line), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .keyline_closed(key), .tone_enable(tone), .mod_data(mod_data), .rx_midbit_clock(mid_clk),
    .baud_tick(tick), .baud_rate_index(rate_idx), .unit_number(unit), .demod_channel(demod_ch),
    .mod_channel(mod_ch), .remote_tx_line(rtx_line), .remote_rx_serial(rrx_ser));
  tx_data_terminal #(.BIT_CYCLES(8)) i_term (.sys_clk(sys_clk), .tx_line(tx_pin));
  // Free-running 20 MHz system clock.
  always #25 sys_clk = ~sys_clk;
  task automatic summarize;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // Waits ending just past an edge, so outputs have settled before checks.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic set_straps(input logic [7:0] b, u, h, l);
    @(posedge sys_clk);
    {baud_sw, unit_sw, dly_hi, dly_lo} <= {b, u, h, l};
    cyc(8);
  endtask : set_straps
  task automatic set_jmp(input logic p, m, f, t);
    @(posedge sys_clk);
    {pol_j, mid_j, fmt_j, tone_j} <= {p, m, f, t};
    cyc(8);
  endtask : set_jmp
  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // Read data stands only in the cycle after the strobe.
  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_read
  task automatic t_regs;
    `CHK(rate_idx, 4'h6)
    `CHK(mod_ch, 5'h02)
    reg_read(DELAY_OFS, d);
    `CHK(d[13:0], 14'd250)
    reg_read(STATUS_OFS, d);
    `CHK({d[11:8], d[7:4]}, 8'h16)
    reg_write(CTRL_OFS, 32'h2);
    reg_read(CTRL_OFS, d);
    `CHK(d, 32'h2)
    `CHK(tone, 1'b1)
    reg_write(4'hc, 32'hffff_ffff);
    reg_read(4'hc, d);
    `CHK(d, 32'h0)
    reg_write(CTRL_OFS, 32'h0);
    $display("registers done");
  endtask : t_regs
  task automatic t_straps;
    int n = 0;
    for (int k = 0; k < 8; k++) begin
      set_straps(8'h1 << k, 8'h1 << k, 8'h02, 8'h50);
      `CHK(rate_idx, 4'(k + 1))
      `CHK({unit, mod_ch, demod_ch}, {4'(k + 1), 5'(2 * k + 2), 5'(2 * k + 1)})
    end
    set_straps(8'h00, 8'h00, 8'h02, 8'h50);
    `CHK({rate_idx, unit, demod_ch, mod_ch}, {4'h0, 4'h9, 5'h11, 5'h12})
    set_straps(8'h05, 8'h48, 8'h02, 8'h50);
    `CHK({rate_idx, unit}, 8'h34)
    set_straps(8'h80, 8'h01, 8'h02, 8'h50);
    for (int i = 0; i < 200 && tick !== 1'b1; i++) cyc(1);
    // The count stops at its bound, so a missing tick still shows as a mismatch.
    do begin
      cyc(1);
      n++;
    end while (tick !== 1'b1 && n < 200);
    `CHK(n, CLOCK_HZ / 38400)
    $display("straps done");
  endtask : t_straps
  task automatic t_delay;
    logic [29:0] tbl [3] = '{{8'h13, 8'h27, 14'd1327}, {8'h99, 8'h99, 14'd9999},
      {8'h00, 8'h01, 14'd1}};
    foreach (tbl[i]) begin
      set_straps(8'h20, 8'h01, tbl[i][29:22], tbl[i][21:14]);
      reg_read(DELAY_OFS, d);
      `CHK(d[13:0], tbl[i][13:0])
    end
    $display("delay done");
  endtask : t_delay
  task automatic t_keyer;
    // A 60-cycle hang spans more than seven 8-cycle bits of the terminal.
    set_straps(8'h20, 8'h01, 8'h00, 8'h03);
    fork
      i_term.burst(6);
      begin
        for (int i = 0; i < 16 && key !== 1'b1; i++) cyc(1);
        `CHK({key, tone}, 2'b11)
      end
    join
    cyc(58);
    `CHK(key, 1'b1)
    cyc(12);
    `CHK({key, tone}, 2'b00)
    set_jmp(1'b0, 1'b0, 1'b0, 1'b1);
    `CHK({key, tone}, 2'b01)
    set_jmp(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk);
    dkr <= 1'b1;
    cyc(8);
    `CHK({key, tone}, 2'b11)
    @(posedge sys_clk);
    dkr <= 1'b0;
    cyc(12);
    `CHK(key, 1'b0)
    $display("keyer done");
  endtask : t_keyer
  task automatic t_polarity;
    set_jmp(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK({mod_data, rtx_line, rrx_ser}, 3'b111)
    set_jmp(1'b0, 1'b0, 1'b1, 1'b0);
    `CHK({mod_data, rtx_line, rrx_ser}, 3'b000)
    for (int j = 0; j < 2; j++) begin
      set_jmp(1'b0, j[0], 1'b0, 1'b0);
      @(posedge sys_clk);
      bit_ctr <= 1'b1;
      @(posedge sys_clk);
      bit_ctr <= 1'b0;
      #1 `CHK(mid_clk, j[0])
      @(posedge sys_clk);
      bit_edge <= 1'b1;
      @(posedge sys_clk);
      bit_edge <= 1'b0;
      #1 `CHK(mid_clk, ~j[0])
    end
    $display("polarity done");
  endtask : t_polarity
  // Watchdog that cuts a hung run short.
  initial begin
    repeat (100000) @(posedge sys_clk);
    $display("[ERR] %0t: run timed out", $time);
    num_errors++;
    summarize();
  end
  // Main sequence: reset, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    cyc(8);
    t_regs();
    t_straps();
    t_delay();
    t_keyer();
    t_polarity();
    summarize();
  end
endmodule : tb_top
bind option_strap_automute_keyer option_strap_monitor #(.MS_CYCLES(MS_CYCLES)) i_mon (
  .sys_clk(sys_clk), .nrst(nrst), .hang_delay_low_bank(hang_delay_low_bank),
  .hang_delay_high_bank(hang_delay_high_bank), .tone_gating_jumper(tone_gating_jumper),
  .rx_midbit_clock_polarity_jumper(rx_midbit_clock_polarity_jumper),
  .tx_data_pin(tx_data_pin), .direct_key_request(direct_key_request),
  .rx_bit_centre(rx_bit_centre), .keyline_closed(keyline_closed), .tone_enable(tone_enable),
  .rx_midbit_clock(rx_midbit_clock), .baud_rate_index(baud_rate_index),
  .unit_number(unit_number), .demod_channel(demod_channel), .mod_channel(mod_channel));
